//--- rtl/conversion_result_buffer.sv
// result sequencer and host read word of the converter result queue
// Contract
// RULE1: in buffer mode every finished result becomes a queue entry, whatever input
// RULE2: after reset the word reads full clear at D15, empty set at D14
// RULE3: word holds result in D11-D0, source tag at D12, reserved D13
// RULE4: full flag D15 set when all 64 entries are unread
// RULE5: empty flag D14 set when no unread entry, already with last result
// RULE6: tag 0 for X, Z1, cell, second spare; 1 for Y, Z2, first spare, temp
// RULE7: touch pair writes Y then X; four values write Y, X, Z1, Z2
// RULE8: autoscan writes first spare, second spare, temperature, skipping unselected
// RULE9: port scan writes cell, first spare, then second spare
// RULE10: each host read returns the oldest entry and advances; drain until empty
`timescale 1ns/1ps
`default_nettype none

module conversion_result_buffer (
   input wire logic clk,
   input wire logic rst,
   input wire logic bufferModeEn,
   input wire conv_buf_pkg::seq_mode_t seqMode,
   input wire logic [2:0] autoSelect,
   input wire logic resultValid,
   input wire logic [11:0] resultData,
   input wire conv_buf_pkg::source_t resultSource,
   output logic resultReady,
   input wire logic readStrobe,
   output logic [15:0] readData,
   output logic readValid,
   output logic queueFull,
   output logic queueEmpty
);

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_COLLECT = 3'b010,
      ST_DRAIN = 3'b100
   } state_t;

   state_t stateQ, stateD;
   conv_buf_pkg::seq_mode_t modeQ, modeD;
   logic [3:0] expectQ, expectD;
   logic [3:0] gotQ, gotD;
   logic [3:0][11:0] slotDataQ, slotDataD;
   logic [3:0] slotTagQ, slotTagD;
   logic [1:0] idxQ, idxD;
   logic [15:0] readDataQ, readDataD;
   logic readValidQ, readValidD;
   logic curTag, goSingle, take, push;
   logic [1:0] newSlot, collectSlot;
   logic [3:0] newExpect;

   queue_if #(.WIDTH(conv_buf_pkg::ENTRY_W), .LW(conv_buf_pkg::LEVEL_W)) qif ();

   result_queue #(
      .WIDTH(conv_buf_pkg::ENTRY_W),
      .DEPTH(conv_buf_pkg::QUEUE_DEPTH),
      .LW(conv_buf_pkg::LEVEL_W)
   ) u_queue (
      .clk(clk),
      .rst(rst),
      .q(qif.store)
   );

   ////////////////////////////////////////////////////////////////////////
   // decode of the arriving result
   assign curTag = conv_buf_pkg::tagOf(resultSource); // RULE6
   assign newExpect = conv_buf_pkg::expectMask(seqMode, autoSelect);
   assign newSlot = conv_buf_pkg::slotOf(seqMode, resultSource);
   assign collectSlot = conv_buf_pkg::slotOf(modeQ, resultSource);
   // a result outside its sequence, or an autoscan with nothing selected, goes in alone
   assign goSingle = (seqMode == conv_buf_pkg::SEQ_SINGLE) || (newExpect == 4'h0) ||
                     !conv_buf_pkg::inMode(seqMode, resultSource) || !newExpect[newSlot];
   assign take = bufferModeEn && resultValid && resultReady;

   // sequencer: gathers one sequence into slots, then writes them in slot order
   always_comb begin
      stateD = stateQ;
      modeD = modeQ;
      expectD = expectQ;
      gotD = gotQ;
      slotDataD = slotDataQ;
      slotTagD = slotTagQ;
      idxD = idxQ;
      resultReady = 1'b1;
      push = 1'b0;
      case (stateQ)
         ST_IDLE: begin
            idxD = 2'h0;
            if (take) begin // RULE1
               if (goSingle) begin
                  modeD = conv_buf_pkg::SEQ_SINGLE;
                  expectD = 4'h1;
                  gotD = 4'h1;
                  slotDataD[0] = resultData;
                  slotTagD[0] = curTag;
                  stateD = ST_DRAIN;
               end else begin
                  modeD = seqMode;
                  expectD = newExpect;
                  gotD = 4'h0;
                  gotD[newSlot] = 1'b1;
                  slotDataD[newSlot] = resultData;
                  slotTagD[newSlot] = curTag;
                  stateD = (gotD == newExpect) ? ST_DRAIN : ST_COLLECT;
               end
            end
         end
         ST_COLLECT: begin
            // a repeat or foreign result waits until this sequence is queued
            resultReady = !bufferModeEn || (conv_buf_pkg::inMode(modeQ, resultSource) &&
                          expectQ[collectSlot] && !gotQ[collectSlot]);
            if (take) begin // RULE7 RULE8 RULE9
               gotD[collectSlot] = 1'b1;
               slotDataD[collectSlot] = resultData;
               slotTagD[collectSlot] = curTag;
            end
            if (gotD == expectQ) begin
               stateD = ST_DRAIN;
            end
         end
         ST_DRAIN: begin
            // back-pressure: a full queue holds the converter here
            resultReady = !bufferModeEn;
            push = gotQ[idxQ];
            if (!gotQ[idxQ] || qif.wrReady) begin // RULE7 RULE8 RULE9
               idxD = 2'(idxQ + 1'b1);
               if (idxQ == conv_buf_pkg::LAST_SLOT) begin
                  stateD = ST_IDLE;
               end
            end
         end
         default: begin
            stateD = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stateQ <= ST_IDLE;
         modeQ <= conv_buf_pkg::SEQ_SINGLE;
         expectQ <= 4'h0;
         gotQ <= 4'h0;
         slotDataQ <= '0;
         slotTagQ <= 4'h0;
         idxQ <= 2'h0;
      end else begin
         stateQ <= stateD;
         modeQ <= modeD;
         expectQ <= expectD;
         gotQ <= gotD;
         slotDataQ <= slotDataD;
         slotTagQ <= slotTagD;
         idxQ <= idxD;
      end
   end

   // entry is {tag, result}
   assign qif.wrValid = push;
   assign qif.wrData = {slotTagQ[idxQ], slotDataQ[idxQ]}; // RULE3

   ////////////////////////////////////////////////////////////////////////
   // host read word: each strobe pops the oldest entry
   assign qif.rdReady = readStrobe; // RULE10
   always_comb begin
      readDataD = readDataQ;
      readValidD = readStrobe;
      if (readStrobe) begin
         if (qif.rdValid) begin
            readDataD = {qif.level == conv_buf_pkg::LEVEL_FULL, // RULE4
                         qif.level == conv_buf_pkg::LEVEL_LAST, // RULE5
                         1'b0, qif.rdData}; // RULE3
         end else begin
            readDataD = conv_buf_pkg::EMPTY_WORD; // RULE5
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         readDataQ <= conv_buf_pkg::RESET_WORD; // RULE2
         readValidQ <= 1'b0;
      end else begin
         readDataQ <= readDataD;
         readValidQ <= readValidD;
      end
   end

   assign readData = readDataQ;
   assign readValid = readValidQ;
   // live status, also usable as a host interrupt source elsewhere
   assign queueFull = (qif.level == conv_buf_pkg::LEVEL_FULL); // RULE4
   assign queueEmpty = (qif.level == conv_buf_pkg::LEVEL_NONE);

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   logic pushDone;
   assign pushDone = push && qif.wrReady;

   chk_reset_word: assert property ($past(rst) |-> readData == conv_buf_pkg::RESET_WORD) // RULE2
      else $error("word not at reset value after reset");
   chk_reserved_zero: assert property (readValid |-> !readData[conv_buf_pkg::RSVD_BIT]) // RULE3
      else $error("reserved bit set in read word");
   chk_full_flag: assert property (readStrobe |=> readData[conv_buf_pkg::FULL_BIT] == // RULE4
                                   ($past(qif.level) == conv_buf_pkg::LEVEL_FULL))
      else $error("full flag does not match queue level");
   chk_empty_flag: assert property (readStrobe && qif.level <= conv_buf_pkg::LEVEL_LAST // RULE5
                                    |=> readData[conv_buf_pkg::EMPTY_BIT])
      else $error("empty flag missing on last or no entry");
   // an empty read must hand back the plain empty word, never stale data
   chk_empty_read: assert property (readStrobe && !qif.rdValid // RULE5
                                    |=> readData == conv_buf_pkg::EMPTY_WORD)
      else $error("empty read returned something other than the empty word");
   // with room in the queue the lone result is pushed in the very next cycle
   chk_single_take: assert property (take && stateQ == ST_IDLE && goSingle && qif.wrReady // RULE1
                                     |=> slotDataQ[0] == $past(resultData) &&
                                     slotTagQ[0] == $past(curTag) && pushDone)
      else $error("single result not captured");
   chk_order_xy: assert property (push && modeQ == conv_buf_pkg::SEQ_XY // RULE7
                                  |-> qif.wrData[conv_buf_pkg::TAG_BIT] == (idxQ == 2'h0))
      else $error("touch pair written out of order");
   // four values go out Y, X, Z1, Z2: only the first and the last carry a one
   chk_order_xyz: assert property (push && modeQ == conv_buf_pkg::SEQ_XYZ // RULE7
                                   |-> qif.wrData[conv_buf_pkg::TAG_BIT] == (idxQ == 2'h0 || idxQ == 2'h3))
      else $error("four value sequence written out of order");
   chk_order_auto: assert property (push && modeQ == conv_buf_pkg::SEQ_AUTO // RULE8
                                    |-> qif.wrData[conv_buf_pkg::TAG_BIT] == (idxQ != 2'h1))
      else $error("autoscan written out of order");
   chk_order_port: assert property (push && modeQ == conv_buf_pkg::SEQ_PORT // RULE9
                                    |-> qif.wrData[conv_buf_pkg::TAG_BIT] == (idxQ == 2'h1))
      else $error("port scan written out of order");
   chk_read_pops: assert property (readStrobe && qif.rdValid && !pushDone // RULE10
                                   |=> qif.level == $past(qif.level) - 1'b1 &&
                                   readData[11:0] == $past(qif.rdData[11:0]))
      else $error("read did not return and pop the oldest entry");

   cov_queue_full: cover property (queueFull ##1 readStrobe);
   cov_xyz_done: cover property (pushDone && modeQ == conv_buf_pkg::SEQ_XYZ && idxQ == 2'h3);
   cov_drain_last: cover property (readStrobe && qif.level == conv_buf_pkg::LEVEL_LAST);
   cov_stall: cover property (stateQ == ST_DRAIN && push && !qif.wrReady);

endmodule : conversion_result_buffer

`default_nettype wire

//--- rtl/conv_buf_pkg.sv
// constants, types and decode functions shared by the conversion result buffer
package conv_buf_pkg;

   localparam int RESULT_W = 12;
   localparam int ENTRY_W = 13;
   localparam int WORD_W = 16;
   localparam int QUEUE_DEPTH = 64;
   localparam int LEVEL_W = 7;
   localparam int SLOTS = 4;
   localparam logic [6:0] LEVEL_FULL = 7'h40;
   localparam logic [6:0] LEVEL_LAST = 7'h01;
   localparam logic [6:0] LEVEL_NONE = 7'h00;

   // word layout
   localparam int FULL_BIT = 15;
   localparam int EMPTY_BIT = 14;
   localparam int RSVD_BIT = 13;
   localparam int TAG_BIT = 12;
   localparam logic [15:0] RESET_WORD = 16'h4000;
   localparam logic [15:0] EMPTY_WORD = 16'h4000;
   localparam logic [1:0] LAST_SLOT = 2'h3;

   // converter input that produced a result
   typedef enum logic [2:0] {
      SRC_X = 3'h0,
      SRC_Y = 3'h1,
      SRC_Z1 = 3'h2,
      SRC_Z2 = 3'h3,
      SRC_CELL = 3'h4,
      SRC_SPARE1 = 3'h5,
      SRC_SPARE2 = 3'h6,
      SRC_TEMP = 3'h7
   } source_t;

   // kind of conversion sequence currently running in the converter
   typedef enum logic [2:0] {
      SEQ_SINGLE = 3'h0,
      SEQ_XY = 3'h1,
      SEQ_XYZ = 3'h2,
      SEQ_AUTO = 3'h3,
      SEQ_PORT = 3'h4
   } seq_mode_t;

   // source tag: one for Y, Z2, first spare and temperature
   function automatic logic tagOf(input source_t src);
      tagOf = (src == SRC_Y) || (src == SRC_Z2) || (src == SRC_SPARE1) || (src == SRC_TEMP);
   endfunction : tagOf

   // queue position of a result within its sequence
   function automatic logic [1:0] slotOf(input seq_mode_t mode, input source_t src);
      slotOf = 2'h0;
      case (mode)
         SEQ_XY, SEQ_XYZ: begin
            case (src)
               SRC_X: slotOf = 2'h1;
               SRC_Z1: slotOf = 2'h2;
               SRC_Z2: slotOf = 2'h3;
               default: slotOf = 2'h0;
            endcase
         end
         SEQ_AUTO: begin
            slotOf = (src == SRC_SPARE2) ? 2'h1 : ((src == SRC_TEMP) ? 2'h2 : 2'h0);
         end
         SEQ_PORT: begin
            slotOf = (src == SRC_SPARE1) ? 2'h1 : ((src == SRC_SPARE2) ? 2'h2 : 2'h0);
         end
         default: slotOf = 2'h0;
      endcase
   endfunction : slotOf

   // does this source belong to the sequence at all
   function automatic logic inMode(input seq_mode_t mode, input source_t src);
      case (mode)
         SEQ_XY: inMode = (src == SRC_X) || (src == SRC_Y);
         SEQ_XYZ: inMode = (src == SRC_X) || (src == SRC_Y) || (src == SRC_Z1) || (src == SRC_Z2);
         SEQ_AUTO: inMode = (src == SRC_SPARE1) || (src == SRC_SPARE2) || (src == SRC_TEMP);
         SEQ_PORT: inMode = (src == SRC_CELL) || (src == SRC_SPARE1) || (src == SRC_SPARE2);
         default: inMode = 1'b0;
      endcase
   endfunction : inMode

   // slots a complete sequence fills; autoSel is {temp, spare2, spare1}
   function automatic logic [3:0] expectMask(input seq_mode_t mode, input logic [2:0] autoSel);
      case (mode)
         SEQ_XY: expectMask = 4'h3;
         SEQ_XYZ: expectMask = 4'hf;
         SEQ_AUTO: expectMask = {1'b0, autoSel};
         SEQ_PORT: expectMask = 4'h7;
         default: expectMask = 4'h1;
      endcase
   endfunction : expectMask

endpackage : conv_buf_pkg

//--- rtl/queue_if.sv
// valid/ready carrier between the result sequencer and its queue
`timescale 1ns/1ps
`default_nettype none

interface queue_if #(parameter int WIDTH = 13, parameter int LW = 7);
   logic wrValid;
   logic wrReady;
   logic [WIDTH-1:0] wrData;
   logic rdValid;
   logic rdReady;
   logic [WIDTH-1:0] rdData;
   logic [LW-1:0] level;

   modport producer (output wrValid, output wrData, input wrReady,
                     input rdValid, input rdData, input level, output rdReady);
   modport store (input wrValid, input wrData, output wrReady,
                  output rdValid, output rdData, output level, input rdReady);
endinterface : queue_if

`default_nettype wire

//--- rtl/result_queue.sv
// flip-flop queue with valid/ready on both sides and an honest fill level
`timescale 1ns/1ps
`default_nettype none

module result_queue #(
   parameter int WIDTH = 13,
   parameter int DEPTH = 64,
   parameter int LW = 7
) (
   input wire logic clk,
   input wire logic rst,
   queue_if.store q
);

   localparam int AW = $clog2(DEPTH);
   localparam logic [LW-1:0] FULL_LVL = LW'(DEPTH);

   logic [WIDTH-1:0] memQ [DEPTH];
   logic [AW-1:0] wrPtrQ, wrPtrD, rdPtrQ, rdPtrD;
   logic [LW-1:0] levelQ, levelD;
   logic doWr, doRd;

   ////////////////////////////////////////////////////////////////////////
   // handshakes: full refuses writes, empty refuses reads
   assign q.wrReady = (levelQ != FULL_LVL);
   assign q.rdValid = (levelQ != '0);
   assign q.rdData = memQ[rdPtrQ];
   assign q.level = levelQ;
   assign doWr = q.wrValid && q.wrReady;
   assign doRd = q.rdValid && q.rdReady;

   // pointer and level arithmetic; pointers wrap naturally at a power of two
   always_comb begin
      wrPtrD = doWr ? AW'(wrPtrQ + 1'b1) : wrPtrQ;
      rdPtrD = doRd ? AW'(rdPtrQ + 1'b1) : rdPtrQ;
      levelD = levelQ;
      if (doWr && !doRd) begin
         levelD = LW'(levelQ + 1'b1);
      end else if (doRd && !doWr) begin
         levelD = LW'(levelQ - 1'b1);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wrPtrQ <= '0;
         rdPtrQ <= '0;
         levelQ <= '0;
      end else begin
         wrPtrQ <= wrPtrD;
         rdPtrQ <= rdPtrD;
         levelQ <= levelD;
      end
   end

   // storage carries no reset; only written slots are ever read
   always_ff @(posedge clk) begin
      if (doWr) begin
         memQ[wrPtrQ] <= q.wrData;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_level_bound: assert property (levelQ <= FULL_LVL) else $error("queue level above depth"); // RULE4
   chk_level_track: assert property (doWr && !doRd |=> levelQ == $past(levelQ) + 1'b1) // RULE1
      else $error("queue level missed a write");
   // a full queue refuses writes, so only a read may move the level off the top
   chk_full_hold: assert property (levelQ == FULL_LVL && !doRd |=> levelQ == FULL_LVL) // RULE4
      else $error("full queue accepted another write");

endmodule : result_queue

`default_nettype wire

//--- verif/host_reader.sv
// host model that pulls words from the result buffer read port
`timescale 1ns/1ps
`default_nettype none

module host_reader (
   input wire logic clk,
   output var logic readStrobe,
   input wire logic readValid,
   input wire logic [15:0] readData
);

   // the strobe rests low; the host only pulses it for one cycle per word
   initial begin
      readStrobe = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // one read: pulse the strobe, take the word in the cycle valid stands
   task automatic readWord(output logic [15:0] w, output logic ok);
      int i;
      ok = 1'b0;
      w = 16'h0000;
      @(negedge clk);
      readStrobe = 1'b1;
      @(negedge clk);
      readStrobe = 1'b0;
      // valid lasts one cycle only, so it is sampled mid-cycle, never late
      for (i = 0; i < 4 && ok !== 1'b1; i++) begin
         if (readValid === 1'b1) begin
            w = readData;
            ok = 1'b1;
         end else begin
            @(negedge clk);
         end
      end
   endtask : readWord

endmodule : host_reader

`default_nettype wire

//--- verif/conversion_result_buffer_tb_top.sv
// self-checking bench for the conversion result buffer
`timescale 1ns/1ps
`default_nettype none

module conversion_result_buffer_tb_top;

   logic clk;
   logic rst;
   logic bufferModeEn;
   conv_buf_pkg::seq_mode_t seqMode;
   logic [2:0] autoSelect;
   logic resultValid;
   logic [11:0] resultData;
   conv_buf_pkg::source_t resultSource;
   logic resultReady;
   logic readStrobe;
   logic [15:0] readData;
   logic readValid;
   logic queueFull;
   logic queueEmpty;
   int n_mismatch = 0;
   int check_count = 0;
   int cycles = 0;
   logic [12:0] expQ[$];
   // tag per source code: Y, Z2, first spare and temperature carry a one
   localparam logic [7:0] TAG_TABLE = 8'haa;

   conversion_result_buffer u_dut (.clk(clk), .rst(rst), .bufferModeEn(bufferModeEn), .seqMode(seqMode),
      .autoSelect(autoSelect), .resultValid(resultValid), .resultData(resultData),
      .resultSource(resultSource), .resultReady(resultReady), .readStrobe(readStrobe),
      .readData(readData), .readValid(readValid), .queueFull(queueFull), .queueEmpty(queueEmpty));

   host_reader u_host (.clk(clk), .readStrobe(readStrobe), .readValid(readValid), .readData(readData));

   // 40 MHz clock
   initial begin
      clk = 1'b0;
   end
   always #12.5 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////
   // shared tasks
   task automatic check(input string what, input logic [15:0] expv, input logic [15:0] got);
      check_count++;
      if (got !== expv) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, expv, got);
      end
   endtask : check

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : report_and_stop

   task automatic waitCycles(input int n);
      repeat (n) @(negedge clk);
   endtask : waitCycles

   task automatic expPush(input int s, input logic [11:0] d);
      expQ.push_back({TAG_TABLE[s[2:0]], d});
   endtask : expPush

   // offer one result and hold it until the buffer takes it at a rising edge
   task automatic sendResult(input int s, input logic [11:0] d);
      int i;
      @(negedge clk);
      resultValid = 1'b1;
      resultSource = conv_buf_pkg::source_t'(s[2:0]);
      resultData = d;
      #1;
      for (i = 0; i < 300 && resultReady !== 1'b1; i++) begin
         @(negedge clk);
         #1;
      end
      check("result taken", 16'h0001, {15'h0000, resultReady});
      @(posedge clk);
      @(negedge clk);
      resultValid = 1'b0;
   endtask : sendResult

   // flags come from the fill level before the pop: full at 64, empty at 1
   task automatic checkRead();
      logic [15:0] w;
      logic ok;
      logic [15:0] e;
      e = 16'h4000;
      if (expQ.size() > 0) begin
         e = {expQ.size() == 64, expQ.size() == 1, 1'b0, expQ[0]};
         void'(expQ.pop_front());
      end
      u_host.readWord(w, ok);
      check("read valid", 16'h0001, {15'h0000, ok});
      check("read word", e, w);
   endtask : checkRead

   // the host keeps reading until the empty flag, then once more
   task automatic drain();
      while (expQ.size() > 0) begin
         checkRead();
      end
      checkRead();
   endtask : drain

   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic testReset();
      check("reset word", 16'h4000, readData);
      check("reset flags", 16'h0001, {14'h0000, queueFull, queueEmpty});
      checkRead();
   endtask : testReset

   task automatic testSingles();
      seqMode = conv_buf_pkg::SEQ_SINGLE;
      for (int s = 0; s < 8; s++) begin
         sendResult(s, 12'hfff - 12'(s * 12'h111));
         expPush(s, 12'hfff - 12'(s * 12'h111));
      end
      waitCycles(8);
      drain();
   endtask : testSingles

   // codes: 0 X, 1 Y, 2 Z1, 3 Z2, 4 cell, 5 spare1, 6 spare2, 7 temp
   task automatic runSeq(input conv_buf_pkg::seq_mode_t m, input logic [2:0] sel, input int sent[4],
                         input int order[4], input int n);
      seqMode = m;
      autoSelect = sel;
      for (int i = 0; i < n; i++) begin
         sendResult(sent[i], 12'h5a0 + 12'(sent[i]));
      end
      for (int i = 0; i < n; i++) begin
         expPush(order[i], 12'h5a0 + 12'(order[i]));
      end
      waitCycles(10);
      drain();
   endtask : runSeq

   task automatic testOrders();
      runSeq(conv_buf_pkg::SEQ_XY, 3'h0, '{0, 1, 0, 0}, '{1, 0, 0, 0}, 2);
      runSeq(conv_buf_pkg::SEQ_XYZ, 3'h0, '{3, 0, 2, 1}, '{1, 0, 2, 3}, 4);
      runSeq(conv_buf_pkg::SEQ_AUTO, 3'h5, '{7, 5, 0, 0}, '{5, 7, 0, 0}, 2);
      runSeq(conv_buf_pkg::SEQ_AUTO, 3'h7, '{6, 7, 5, 0}, '{5, 6, 7, 0}, 3);
      runSeq(conv_buf_pkg::SEQ_PORT, 3'h0, '{6, 5, 4, 0}, '{4, 5, 6, 0}, 3);
      // a foreign input, or an autoscan with nothing selected, is queued alone
      runSeq(conv_buf_pkg::SEQ_XY, 3'h0, '{7, 0, 0, 0}, '{7, 0, 0, 0}, 1);
      runSeq(conv_buf_pkg::SEQ_AUTO, 3'h0, '{6, 0, 0, 0}, '{6, 0, 0, 0}, 1);
   endtask : testOrders

   // fill all 64 places; first word reads full, last reads empty
   task automatic testFull();
      seqMode = conv_buf_pkg::SEQ_SINGLE;
      for (int i = 0; i < 64; i++) begin
         sendResult(i % 8, 12'(i));
         expPush(i % 8, 12'(i));
      end
      waitCycles(10);
      check("full flag", 16'h0001, {15'h0000, queueFull});
      drain();
   endtask : testFull

   // with buffer mode off results are taken but never queued
   task automatic testModeOff();
      bufferModeEn = 1'b0;
      sendResult(1, 12'h123);
      waitCycles(8);
      check("empty when off", 16'h0001, {15'h0000, queueEmpty});
      checkRead();
      bufferModeEn = 1'b1;
   endtask : testModeOff

   // a reset in mid-run drops unread entries and restores the word
   task automatic testMidReset();
      seqMode = conv_buf_pkg::SEQ_SINGLE;
      sendResult(2, 12'h0a5);
      sendResult(3, 12'h05a);
      expPush(2, 12'h0a5);
      expPush(3, 12'h05a);
      waitCycles(8);
      checkRead();
      rst = 1'b1;
      @(negedge clk);
      rst = 1'b0;
      expQ.delete();
      check("word after reset", 16'h4000, readData);
      check("empty after reset", 16'h0001, {15'h0000, queueEmpty});
      checkRead();
   endtask : testMidReset

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      rst = 1'b1;
      bufferModeEn = 1'b1;
      seqMode = conv_buf_pkg::SEQ_SINGLE;
      autoSelect = 3'h0;
      resultValid = 1'b0;
      resultData = 12'h000;
      resultSource = conv_buf_pkg::SRC_X;
      repeat (2) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      testReset();
      testSingles();
      testOrders();
      testFull();
      testModeOff();
      testMidReset();
      report_and_stop();
   end

   // the whole run needs under a thousand cycles; a hang is cut well beyond
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         n_mismatch++;
         $display("mismatch run length expected done seen running");
         report_and_stop();
      end
   end

endmodule : conversion_result_buffer_tb_top

`default_nettype wire
